// ==== verification/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tvb_defs.svh"
module tb;
  logic clk_sys, nrst, keyOn, swOn, push, keyBypass, sdvBypSw, resetSw;
  logic [3:0] gTrip, lTrip, dTrip, cTrip, vHigh, lowPwr, stShut;
  logic [3:0] genOk, levelOk, drywellOk, cvFastOk, sdvLevelOk, fsBelow, stopOpen;
  logic [3:0] modeRun, modeHalt, modeFuel, modeHeat, groupA, groupB, s_axi_wstrb;
  logic [7:0] isoShut, isoOpen, s_axi_awaddr, s_axi_araddr;
  logic [1:0] mode, s_axi_bresp, s_axi_rresp, r;
  logic scram, ventOpen, rodBlock, annHalt, annTurb, annSdv;
  logic [15:0] bypassStat;
  logic [11:0] isolationOk;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] md [3] = '{2'h0, 2'h2, 2'h3};
  int nMismatch, checked;
  tvb_plant_model i_plant (.*);
  tvb_voting_logic #(.HALT_DLY_CYC(20), .RESET_INH_CYC(40)) i_dut (.*);
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : w
  task automatic st(input int n);
    w(n);
    @(negedge clk_sys);
  endtask : st
  task automatic ck(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      nMismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask : ck
  task automatic done(input string n);
    $display("test %s done", n);
  endtask : done
  task automatic rst;
    w(1);
    push <= 1'h1;
    w(4);
    push <= 1'h0;
    st(4);
  endtask : rst
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    w(1);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      w(1);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    rs = s_axi_bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    w(1);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      w(1);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    v = s_axi_rdata;
    rs = s_axi_rresp;
  endtask : rd
  task automatic wrap_up;
    $display("mismatches %0d of %0d checks", nMismatch, checked);
    if (nMismatch == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (6000) @(posedge clk_sys);
    nMismatch++;
    wrap_up;
  end
  initial begin
    nrst = 1'h0;
    {gTrip, lTrip, dTrip, cTrip, vHigh, lowPwr, stShut, isoShut, mode} = '0;
    {keyOn, swOn, push, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    w(4);
    nrst <= 1'h1;
    st(8);
    ck(scram, 1);
    ck({groupA, groupB, ventOpen}, 0);
    rst;
    ck(scram, 1);
    w(48);
    rst;
    ck({groupA, groupB, ventOpen}, 9'h1ff);
    done("power-up");
    for (int l = 0; l < 4; l++) begin
      w(1);
      gTrip <= 4'h1 << l;
      st(6);
      ck(groupA, (l < 2) ? 4'h0 : 4'hf);
      ck(groupB, (l < 2) ? 4'hf : 4'h0);
      ck(scram, 0);
      w(1);
      gTrip <= 4'h0;
      rst;
      ck({groupA, groupB}, 8'hff);
    end
    done("one of two");
    w(1);
    lTrip <= 4'h5;
    dTrip <= 4'ha;
    st(6);
    ck(isolationOk, 12'hf5a);
    w(1);
    {lTrip, dTrip} <= '0;
    st(6);
    ck(scram, 1);
    w(48);
    rst;
    ck(scram, 0);
    done("seal-in");
    foreach (md[i]) begin
      w(1);
      mode <= md[i];
      w(4);
      isoShut <= 8'h09;
      st(6);
      ck(groupA, md[i] == 2'h0 ? 4'h0 : 4'hf);
      ck(groupB, 4'hf);
      ck(bypassStat[3:0], md[i] == 2'h0 ? 4'h0 : 4'hf);
      w(1);
      isoShut <= 8'h00;
      rst;
    end
    done("isolation");
    w(1);
    mode <= 2'h0;
    stShut <= 4'h3;
    lowPwr <= 4'h1;
    st(6);
    ck({groupA, groupB}, 8'hff);
    ck({annTurb, bypassStat[7:4]}, 5'h11);
    w(1);
    {lowPwr, cTrip, stShut} <= 12'hff7;
    st(6);
    ck({groupA, groupB}, 8'hff);
    w(1);
    lowPwr <= 4'h0;
    st(6);
    ck(scram, 1);
    w(1);
    {cTrip, stShut} <= '0;
    w(48);
    rst;
    done("turbine");
    w(1);
    {mode, keyOn, swOn, vHigh} <= 8'hbf;
    st(6);
    ck({rodBlock, annSdv, bypassStat[11:8]}, 6'h3f);
    ck(scram, 0);
    w(1);
    mode <= 2'h0;
    st(6);
    ck({rodBlock, scram}, 2'h1);
    w(1);
    {keyOn, swOn, vHigh} <= '0;
    w(48);
    rst;
    done("discharge");
    w(1);
    mode <= 2'h1;
    st(6);
    ck({scram, annHalt}, 2'h2);
    st(24);
    ck({annHalt, bypassStat[15:12]}, 5'h1f);
    w(48);
    rst;
    ck(scram, 0);
    w(1);
    isoShut <= 8'h09;
    st(6);
    ck({groupA, groupB}, 8'hff);
    w(1);
    isoShut <= 8'h00;
    w(1);
    mode <= 2'h0;
    st(6);
    ck(annHalt, 0);
    done("halt");
    wr(`TVB_REG_CTRL, 32'h1, r);
    st(6);
    ck({r, groupA, groupB}, 10'h00f);
    rd(`TVB_REG_STATUS, d, r);
    ck(d[6:4], 3'h1);
    wr(`TVB_REG_CTRL, 32'h0, r);
    rst;
    rd(`TVB_REG_BYPASS, d, r);
    ck(d, 0);
    ck(r, `TVB_RESP_OKAY);
    rd(8'h10, d, r);
    ck(d, 0);
    ck(r, `TVB_RESP_SLVERR);
    wr(8'h10, 32'h1, r);
    ck(r, `TVB_RESP_SLVERR);
    done("registers");
    wrap_up;
  end
endmodule : tb
`default_nettype wire

// ==== verification/tvb_plant_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module tvb_plant_model (
  // Plant events, high = tripped or closed, except lowPwr, high when below bypass pressure
  input wire logic [3:0] gTrip,
  input wire logic [3:0] lTrip,
  input wire logic [3:0] dTrip,
  input wire logic [3:0] cTrip,
  input wire logic [3:0] vHigh,
  input wire logic [3:0] lowPwr,
  input wire logic [3:0] stShut,
  input wire logic [7:0] isoShut,
  // Panel
  input wire logic [1:0] mode,
  input wire logic keyOn,
  input wire logic swOn,
  input wire logic push,
  // Contacts towards the block
  output logic [3:0] genOk,
  output logic [3:0] levelOk,
  output logic [3:0] drywellOk,
  output logic [3:0] cvFastOk,
  output logic [3:0] sdvLevelOk,
  output logic [3:0] fsBelow,
  output logic [3:0] stopOpen,
  output logic [7:0] isoOpen,
  output logic [3:0] modeRun,
  output logic [3:0] modeHalt,
  output logic [3:0] modeFuel,
  output logic [3:0] modeHeat,
  output logic keyBypass,
  output logic sdvBypSw,
  output logic resetSw
);
  assign genOk = ~gTrip;
  assign levelOk = ~lTrip;
  assign drywellOk = ~dTrip;
  assign cvFastOk = ~cTrip;
  assign sdvLevelOk = ~vHigh;
  assign fsBelow = lowPwr;
  assign stopOpen = ~stShut;
  assign isoOpen = ~isoShut;
  assign modeRun = {4{mode == 2'h0}};
  assign modeHalt = {4{mode == 2'h1}};
  assign modeFuel = {4{mode == 2'h2}};
  assign modeHeat = {4{mode == 2'h3}};
  assign keyBypass = keyOn;
  assign sdvBypSw = swOn;
  assign resetSw = push;
endmodule : tvb_plant_model
`default_nettype wire

// ==== verilog/tvb_defs.svh ====
`ifndef TVB_DEFS_SVH
`define TVB_DEFS_SVH
// Register byte offsets
`define TVB_REG_CTRL 8'h00
`define TVB_REG_STATUS 8'h04
`define TVB_REG_BYPASS 8'h08
// Bus widths and responses
`define TVB_AW 8
`define TVB_RESP_OKAY 2'b00
`define TVB_RESP_SLVERR 2'b10
// Synchronised input vector layout
`define TVB_NIN 59
`define TVB_IN_GEN 0
`define TVB_IN_LEVEL 4
`define TVB_IN_DRYWELL 8
`define TVB_IN_CVFAST 12
`define TVB_IN_SDVLVL 16
`define TVB_IN_FSBELOW 20
`define TVB_IN_STOP 24
`define TVB_IN_ISO 28
`define TVB_IN_RUN 36
`define TVB_IN_HALT 40
`define TVB_IN_FUEL 44
`define TVB_IN_HEAT 48
`define TVB_IN_KEY 52
`define TVB_IN_SDVSW 53
`define TVB_IN_RESET 54
`define TVB_IN_SPARE 55
// Timing
`define TVB_CLK_KHZ 125000
`define TVB_HALT_DLY_MS 2000
`define TVB_RST_INH_MS 10000
`define TVB_CNT_W 31
`endif

// ==== verilog/tvb_pkg.sv ====
`default_nettype none
`include "tvb_defs.svh"
package tvb_pkg;
  typedef struct packed {
    logic [`TVB_NIN-1:0] sync1;
    logic [`TVB_NIN-1:0] sync2;
    logic resetPrev;
    logic [1:0] latch;
    logic [`TVB_CNT_W-1:0] haltCnt;
    logic haltByp;
    logic [`TVB_CNT_W-1:0] inhCnt;
    logic [3:0] testTrip;
    logic [15:0] bypStat;
    logic annHalt;
    logic annTurb;
    logic annSdv;
    logic rodBlock;
    logic ventOpen;
    logic scram;
    logic [3:0] grpA;
    logic [3:0] grpB;
    logic [11:0] isoOut;
    logic up;
    logic awready;
    logic wready;
    logic awHeld;
    logic wHeld;
    logic [`TVB_AW-1:0] awaddr;
    logic [3:0] wData;
    logic wStrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tvb_state_type;
endpackage : tvb_pkg
`default_nettype wire

// ==== verilog/tvb_voting_logic.sv ====
// Contract
// - Two trip systems, each with two automatic trip logics, four in all.
// - Every variable except isolation (eight) and stop valves (all four voted in each logic) has four channels, one per automatic trip logic.
// - Either logic of a trip system trips that system: one of two.
// - Scram only when both trip systems are tripped.
// - Bypass status of every bypassed component is output continuously.
// - Isolation-valve scram bypassed in halt, fuel-handling or heatup.
// - Halt-position scram bypassed after a short delay, with annunciator.
// - Turbine valve scrams bypassed below 29.5 percent first-stage pressure.
// - Four pressure channels; any one in bypass annunciates.
// - Discharge-volume bypass needs both keyswitches and halt or fuel-handling.
// - Four discharge-volume bypass channels, one per mode bank and logic.
// - Discharge-volume bypass asserts rod block and annunciator.
// - Reset actuators command vent and drain valves open.
// - Tripped actuators seal in until a momentary reset.
// - Single channel trip resets immediately on reset.
// - After full scram, reset ignored for 10 seconds.
// - Level, drywell, stop-valve states copied to isolation control outputs.
// - Tripped actuator logic de-energises pilot solenoids; both needed per rod.
// - One solenoid per rod from system A, other from system B.
// - Four group outputs per trip system, eight in all.
// - Isolation-valve scram active only in power position.
// - Isolation logic trips only with a closed valve in both its lines.
// - Stop-valve trip needs three or more of four valves closed.
`timescale 1ns/100ps
`default_nettype none
`include "tvb_defs.svh"
module tvb_voting_logic #(
  parameter logic [`TVB_CNT_W-1:0] HALT_DLY_CYC =
    `TVB_CNT_W'(`TVB_HALT_DLY_MS * `TVB_CLK_KHZ),
  parameter logic [`TVB_CNT_W-1:0] RESET_INH_CYC =
    `TVB_CNT_W'(`TVB_RST_INH_MS * `TVB_CLK_KHZ)
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Sensor channels, per logic except stopOpen and isoOpen, high when healthy except fsBelow, high when bypassed
  input wire logic [3:0] genOk,
  input wire logic [3:0] levelOk,
  input wire logic [3:0] drywellOk,
  input wire logic [3:0] cvFastOk,
  input wire logic [3:0] sdvLevelOk,
  input wire logic [3:0] fsBelow,
  input wire logic [3:0] stopOpen,
  input wire logic [7:0] isoOpen,
  // Mode selector banks and panel switches
  input wire logic [3:0] modeRun,
  input wire logic [3:0] modeHalt,
  input wire logic [3:0] modeFuel,
  input wire logic [3:0] modeHeat,
  input wire logic keyBypass,
  input wire logic sdvBypSw,
  input wire logic resetSw,
  // Actuators and annunciators
  output logic [3:0] groupA,
  output logic [3:0] groupB,
  output logic scram,
  output logic ventOpen,
  output logic rodBlock,
  output logic annHalt,
  output logic annTurb,
  output logic annSdv,
  output logic [15:0] bypassStat,
  output logic [11:0] isolationOk,
  // AXI4-Lite slave
  input wire logic [`TVB_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`TVB_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  tvb_pkg::tvb_state_type st;
  tvb_pkg::tvb_state_type next_st;
  logic [`TVB_NIN-1:0] rawIn;
  logic [3:0] sGen, sLevel, sDry, sCv, sSdvLvl, sFs, sStop, sRun, sHalt, sFuel, sHeat;
  logic [7:0] sIso;
  logic sKey, sSdvSw, sReset;
  logic [3:0] logicOk, isoTrip, isoByp, turbByp, sdvByp, haltTrip;
  logic [1:0] sysTrip;
  logic svTrip, resetPulse, inhDone;

  assign rawIn = {4'h0, resetSw, sdvBypSw, keyBypass, modeHeat, modeFuel, modeHalt,
    modeRun, isoOpen, stopOpen, fsBelow, sdvLevelOk, cvFastOk, drywellOk, levelOk, genOk};
  assign sGen = st.sync2[`TVB_IN_GEN +: 4];
  assign sLevel = st.sync2[`TVB_IN_LEVEL +: 4];
  assign sDry = st.sync2[`TVB_IN_DRYWELL +: 4];
  assign sCv = st.sync2[`TVB_IN_CVFAST +: 4];
  assign sSdvLvl = st.sync2[`TVB_IN_SDVLVL +: 4];
  assign sFs = st.sync2[`TVB_IN_FSBELOW +: 4];
  assign sStop = st.sync2[`TVB_IN_STOP +: 4];
  assign sIso = st.sync2[`TVB_IN_ISO +: 8];
  assign sRun = st.sync2[`TVB_IN_RUN +: 4];
  assign sHalt = st.sync2[`TVB_IN_HALT +: 4];
  assign sFuel = st.sync2[`TVB_IN_FUEL +: 4];
  assign sHeat = st.sync2[`TVB_IN_HEAT +: 4];
  assign sKey = st.sync2[`TVB_IN_KEY];
  assign sSdvSw = st.sync2[`TVB_IN_SDVSW];
  assign sReset = st.sync2[`TVB_IN_RESET];

  assign svTrip = ($countones(~sStop) >= 3);

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gLogic
      localparam int LA = (g == 1) ? 2 : ((g == 3) ? 1 : 0);
      localparam int LB = (g == 0) ? 1 : ((g == 2) ? 2 : 3);
      assign isoTrip[g] = ~(sIso[2*LA] & sIso[2*LA+1]) & ~(sIso[2*LB] & sIso[2*LB+1]);
      assign isoByp[g] = ~sRun[g] | sHalt[g] | sFuel[g] | sHeat[g];
      assign turbByp[g] = sFs[g];
      assign sdvByp[g] = sKey & sSdvSw & (sHalt[g] | sFuel[g]);
      assign haltTrip[g] = sHalt[g] & ~st.haltByp;
      assign logicOk[g] = sGen[g] & sLevel[g] & sDry[g] & ~st.testTrip[g]
        & (sSdvLvl[g] | sdvByp[g]) & ~(isoTrip[g] & ~isoByp[g])
        & ((sCv[g] & ~svTrip) | turbByp[g]) & ~haltTrip[g];
    end
  endgenerate

  assign sysTrip[0] = ~logicOk[0] | ~logicOk[1];
  assign sysTrip[1] = ~logicOk[2] | ~logicOk[3];
  assign resetPulse = sReset & ~st.resetPrev;
  assign inhDone = (st.inhCnt >= RESET_INH_CYC);

  always_comb begin
    next_st = st;
    next_st.sync1 = rawIn;
    next_st.sync2 = st.sync1;
    next_st.resetPrev = sReset;
    if (|sHalt) begin
      if (st.haltCnt < HALT_DLY_CYC) begin
        next_st.haltCnt = st.haltCnt + 1'b1;
      end else begin
        next_st.haltByp = 1'b1;
      end
    end else begin
      next_st.haltCnt = '0;
      next_st.haltByp = 1'b0;
    end
    if (!st.scram) begin
      next_st.inhCnt = '0;
    end else if (!inhDone) begin
      next_st.inhCnt = st.inhCnt + 1'b1;
    end
    for (int s = 0; s < 2; s++) begin
      if (sysTrip[s]) begin
        next_st.latch[s] = 1'b1;
      end else if (resetPulse && (!st.scram || inhDone)) begin
        next_st.latch[s] = 1'b0;
      end
    end
    next_st.scram = &next_st.latch;
    next_st.grpA = {4{~next_st.latch[0]}};
    next_st.grpB = {4{~next_st.latch[1]}};
    next_st.ventOpen = ~(|next_st.latch);
    next_st.rodBlock = |sdvByp;
    next_st.annSdv = |sdvByp;
    next_st.annTurb = |turbByp;
    next_st.annHalt = st.haltByp;
    next_st.bypStat = {{4{st.haltByp}}, sdvByp, turbByp, isoByp};
    next_st.isoOut = {sStop, sDry, sLevel};
    // Bus slave
    if (!st.up) begin
      next_st.up = 1'b1;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
      next_st.arready = 1'b1;
    end
    if (s_axi_awvalid && st.awready) begin
      next_st.awHeld = 1'b1;
      next_st.awaddr = s_axi_awaddr;
      next_st.awready = 1'b0;
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.wHeld = 1'b1;
      next_st.wData = s_axi_wdata[3:0];
      next_st.wStrb0 = s_axi_wstrb[0];
      next_st.wready = 1'b0;
    end
    if (next_st.awHeld && next_st.wHeld && !st.bvalid) begin
      next_st.bvalid = 1'b1;
      next_st.awHeld = 1'b0;
      next_st.wHeld = 1'b0;
      next_st.bresp = `TVB_RESP_OKAY;
      if (next_st.awaddr == `TVB_REG_CTRL) begin
        if (next_st.wStrb0) begin
          next_st.testTrip = next_st.wData;
        end
      end else if (next_st.awaddr != `TVB_REG_STATUS && next_st.awaddr != `TVB_REG_BYPASS) begin
        next_st.bresp = `TVB_RESP_SLVERR;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready = 1'b1;
    end
    if (s_axi_arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.rvalid = 1'b1;
      next_st.rresp = `TVB_RESP_OKAY;
      if (s_axi_araddr == `TVB_REG_CTRL) begin
        next_st.rdata = {28'h0000000, st.testTrip};
      end else if (s_axi_araddr == `TVB_REG_STATUS) begin
        next_st.rdata = {19'h00000, st.ventOpen, st.rodBlock, st.annSdv, st.annTurb,
          st.annHalt, st.scram & ~inhDone, st.scram, st.latch, logicOk};
      end else if (s_axi_araddr == `TVB_REG_BYPASS) begin
        next_st.rdata = {16'h0000, st.bypStat};
      end else begin
        next_st.rdata = 32'h00000000;
        next_st.rresp = `TVB_RESP_SLVERR;
      end
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign groupA = st.grpA;
  assign groupB = st.grpB;
  assign scram = st.scram;
  assign ventOpen = st.ventOpen;
  assign rodBlock = st.rodBlock;
  assign annHalt = st.annHalt;
  assign annTurb = st.annTurb;
  assign annSdv = st.annSdv;
  assign bypassStat = st.bypStat;
  assign isolationOk = st.isoOut;
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = st.arready;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

  default clocking cbSys @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  a_one_of_two: assert property (
    !logicOk[1] |=> st.latch[0] && !groupA[0]) else $error("system A not tripped");
  a_single_sys: assert property (
    (st.latch == 2'b01) |-> !scram) else $error("scram on one system");
  a_scram_groups: assert property (
    scram |-> (groupA == 4'h0) && (groupB == 4'h0) && !ventOpen) else $error("groups live");
  a_reset_inhibit: assert property (
    (scram && !inhDone && !(|sysTrip)) |=> scram) else $error("reset during inhibit");
  a_reset_single: assert property (
    (!scram && resetPulse && !(|sysTrip)) |=> (st.latch == 2'b00) && ventOpen)
    else $error("single trip not reset");
  a_seal_in: assert property (
    (st.latch[1] && !resetPulse) |=> st.latch[1]) else $error("seal-in lost");
  a_rod_block: assert property (
    (|sdvByp) |=> rodBlock && annSdv) else $error("no rod block");
  a_turb_ann: assert property (
    $rose(|sFs) |=> annTurb) else $error("turbine bypass not annunciated");
  a_iso_bypass: assert property (
    (sHalt[0] && isoTrip[0] && sGen[0] && sLevel[0] && sDry[0] && sSdvLvl[0]
      && sCv[0] && !svTrip && st.haltByp && !st.testTrip[0]) |-> logicOk[0])
    else $error("isolation trip in halt");
  a_halt_bypass: assert property (
    (|sHalt && st.haltCnt == HALT_DLY_CYC) |=> st.haltByp ##1 annHalt)
    else $error("halt bypass missing");
  a_halt_trip: assert property (
    (&sHalt && !st.haltByp) |=> (st.latch == 2'b11)) else $error("halt did not trip");
  a_sys_apart: assert property (
    (logicOk[3:2] == 2'b11 && !st.latch[1]) |=> !st.latch[1])
    else $error("system B tripped by system A");
  a_channel_path: assert property (
    $fell(genOk[2]) |-> ##2 !logicOk[2]) else $error("channel did not reach its logic");
  a_turb_bypass: assert property (
    (sFs[0] && sGen[0] && sLevel[0] && sDry[0] && sSdvLvl[0] && !isoTrip[0]
      && !sHalt[0] && !st.testTrip[0]) |-> logicOk[0])
    else $error("turbine trip not bypassed");
  a_stop_vote: assert property (
    (!sFs[1] && ($countones(~sStop) >= 3)) |-> !logicOk[1]) else $error("stop valves missed");
  a_iso_power: assert property (
    (sRun[0] && !(sHalt[0] || sFuel[0] || sHeat[0]) && isoTrip[0]) |-> !logicOk[0])
    else $error("isolation trip lost in power");
  a_iso_lines: assert property (
    (&sIso[1:0]) |-> !isoTrip[0] && !isoTrip[2]) else $error("isolation trip on one line");
  a_sdv_permit: assert property (
    (|sdvByp) |-> sKey && sSdvSw && (|(sHalt | sFuel)))
    else $error("discharge bypass unpermitted");
  a_sdv_bank: assert property (
    sdvByp[1] |-> (sHalt[1] || sFuel[1])) else $error("discharge bypass off its bank");
  a_vent_open: assert property (
    $past(nrst) |-> ventOpen == (st.latch == 2'b00)) else $error("vent command wrong");
  a_sys_b_drive: assert property (
    ($past(nrst) && !st.latch[1]) |-> (groupB == 4'hf)) else $error("system B drive dropped");
  a_groups_alike: assert property (
    (groupA == 4'h0 || groupA == 4'hf) && (groupB == 4'h0 || groupB == 4'hf))
    else $error("groups split");
  a_bypass_stat: assert property (
    $past(nrst) |-> bypassStat == $past({{4{st.haltByp}}, sdvByp, turbByp, isoByp}))
    else $error("bypass status stale");
  a_iso_copy: assert property (
    ($past(nrst, 1) && $past(nrst, 2) && $past(nrst, 3))
      |-> isolationOk == $past({stopOpen, drywellOk, levelOk}, 3))
    else $error("isolation copy wrong");
  a_input_sync: assert property (
    ($past(nrst, 1) && $past(nrst, 2)) |-> sReset == $past(resetSw, 2))
    else $error("reset input not synchronised");
endmodule : tvb_voting_logic
`default_nettype wire
